// >>> rtl/wdc_reset_ctrl.sv
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
module wdc_reset_ctrl import wdc_pkg::*; (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_wb_cyc,
	input  wire logic             i_wb_stb,
	input  wire logic             i_wb_we,
	input  wire logic [WB_AW-1:0] i_wb_adr,
	input  wire logic [3:0]       i_wb_sel,
	input  wire logic [WB_DW-1:0] i_wb_dat,
	output logic      [WB_DW-1:0] o_wb_dat,
	output logic                  o_wb_ack,
	input  wire logic             i_slow_osc,
	input  wire logic             i_wdt_clear_instr,
	input  wire logic             i_halt_instr,
	input  wire logic             i_low_power,
	input  wire logic             i_reset_pin_n,
	output logic                  o_core_reset,
	output logic                  o_pc_sp_clear,
	output logic                  o_port_preset,
	output logic                  o_reset_pin_mode,
	output logic                  o_expiry_flag,
	output logic                  o_power_down_flag
);

	// ****************************************
	// State
	// ****************************************
	wdc_state_t           state_r;
	wdc_state_t           state_nxt;
	logic [DLY_W-1:0]     dly_r;
	logic [7:0]           wdt_ctrl_r;
	logic [7:0]           pin_key_r;
	logic [3:0]           cause_r;
	logic [3:0]           cause_nxt;
	logic                 expiry_r;
	logic                 pdown_r;
	logic                 err_en_r;
	logic                 err_pin_r;
	logic                 timeout_r;
	logic                 slow_osc_r;
	logic                 pc_sp_clr_r;
	logic                 port_preset_r;
	logic                 ack_r;
	logic [WB_DW-1:0]     rdat_r;
	logic [WDT_CNT_W-1:0] timer_count;
	logic                 timer_ovf;

	// ****************************************
	// Key decode and watchdog clear sources
	// ****************************************
	wire [4:0] en_key      = wdt_ctrl_r[EN_KEY_MSB:EN_KEY_LSB];
	wire       wdt_on      = (en_key == EN_KEY_ENABLE);                  // RQ3
	wire       en_key_bad  = ~wdt_on & (en_key != EN_KEY_DISABLE);        // RQ4 RQ22
	wire       pin_key_bad = (pin_key_r != PIN_KEY_IO) &
		(pin_key_r != PIN_KEY_RESET);                                    // RQ12 RQ22
	wire       pin_mode    = (pin_key_r == PIN_KEY_RESET);               // RQ11
	wire       pin_low     = pin_mode & ~i_reset_pin_n;
	wire       in_run      = (state_r == ST_RUN);
	wire       core_rst    = (state_r == ST_RESET) | (state_r == ST_PIN_HOLD) |
		(state_r == ST_PIN_DELAY);
	wire       slow_tick   = i_slow_osc & ~slow_osc_r;                  // RQ1
	wire       timer_clear = en_key_bad | i_wdt_clear_instr | i_halt_instr |
		pin_low | core_rst;                                              // RQ9 RQ10
	wire       ovf_run     = timer_ovf & ~i_low_power;
	wire       ovf_sleep   = timer_ovf & i_low_power;
	wire       any_key_bad = en_key_bad | pin_key_bad;
	wire       dly_done    = (state_r == ST_KEY_WAIT) ? (dly_r == KEY_ERR_LAST) :
		(dly_r == PIN_DLY_LAST);
	wire       hold_exit   = (state_r == ST_PIN_HOLD) & ~pin_low;
	wire       full_reset  = (state_r == ST_RESET) & ~timeout_r;
	wire       warm_reset  = (state_r == ST_RESET) & timeout_r;

	// ****************************************
	// Wishbone decode
	// ****************************************
	wire       wb_req   = i_wb_cyc & i_wb_stb & ~ack_r;
	wire       wb_wr    = wb_req & i_wb_we & i_wb_sel[0];
	wire       sel_ctrl = (i_wb_adr == ADR_WDT_CTRL);
	wire       sel_pin  = (i_wb_adr == ADR_PIN_KEY);
	wire       sel_cau  = (i_wb_adr == ADR_CAUSE);
	wire       sel_st   = (i_wb_adr == ADR_STATUS);
	wire       wr_ctrl  = wb_wr & sel_ctrl & ~core_rst;
	wire       wr_pin   = wb_wr & sel_pin & ~core_rst;
	wire       wr_cau   = wb_wr & sel_cau;
	wire [WB_DW-1:0] rd_mux =
		sel_ctrl ? {24'h000000, wdt_ctrl_r} :
		sel_pin  ? {24'h000000, pin_key_r} :
		sel_cau  ? {28'h0000000, cause_r} :                              // RQ17
		sel_st   ? {30'h0, pdown_r, expiry_r} :
		32'h00000000;

	// ****************************************
	// Watchdog counter
	// ****************************************
	wdc_timer u_timer (
		.i_sys_clk    (i_sys_clk),
		.i_rst_n      (i_rst_n),
		.i_tick       (slow_tick),
		.i_clear      (timer_clear),
		.i_enable     (wdt_on),
		.i_period_sel (wdt_ctrl_r[PSEL_MSB:PSEL_LSB]),
		.o_count      (timer_count),
		.o_overflow   (timer_ovf)
	);

	// ****************************************
	// Reset sequencer
	// ****************************************
	// Next state of the reset sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_RUN: begin
				if (pin_low) begin
					state_nxt = ST_PIN_HOLD;
				end else if (ovf_run) begin
					state_nxt = ST_RESET;                               // RQ7
				end else if (any_key_bad) begin
					state_nxt = ST_KEY_WAIT;                            // RQ4 RQ12
				end
			end
			ST_KEY_WAIT: begin
				if (dly_done) begin
					state_nxt = ST_RESET;
				end
			end
			ST_RESET: begin
				state_nxt = ST_RUN;
			end
			ST_PIN_HOLD: begin
				if (!pin_low) begin
					state_nxt = ST_PIN_DELAY;
				end
			end
			ST_PIN_DELAY: begin
				if (dly_done) begin
					state_nxt = ST_RUN;                                 // RQ14
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	// Sequencer state and delay count
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= ST_RUN;
			dly_r   <= '0;
		end else begin
			state_r <= state_nxt;
			dly_r   <= (state_nxt != state_r) ? '0 : dly_r + 1'b1;
		end
	end

	// Cause of the pending reset, caught as the sequence starts
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			err_en_r  <= 1'b0;
			err_pin_r <= 1'b0;
			timeout_r <= 1'b0;
		end else if (in_run) begin
			err_en_r  <= en_key_bad;
			err_pin_r <= pin_key_bad;
			timeout_r <= ovf_run & ~pin_low;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	// Enable key and period; restored on full resets
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wdt_ctrl_r <= WDT_CTRL_POR;                                 // RQ5
		end else if (full_reset | hold_exit) begin
			wdt_ctrl_r <= WDT_CTRL_POR;
		end else if (wr_ctrl) begin
			wdt_ctrl_r <= i_wb_dat[7:0];
		end
	end

	// Reset pin key; a timeout warm reset leaves it alone
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_key_r <= PIN_KEY_POR;                                   // RQ13
		end else if (full_reset | hold_exit) begin
			pin_key_r <= PIN_KEY_POR;                                   // RQ20
		end else if (wr_pin) begin
			pin_key_r <= i_wb_dat[7:0];
		end
	end

	// Sticky cause flags: a zero write clears, a hardware set wins
	assign cause_nxt = (wr_cau ? (cause_r & i_wb_dat[3:0]) : cause_r) |    // RQ6
		{full_reset & err_pin_r, 2'b00, full_reset & err_en_r};           // RQ4 RQ19

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cause_r <= CAUSE_POR;
		end else begin
			cause_r <= cause_nxt;
		end
	end

	// Expiry and power-down status flags
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			expiry_r <= 1'b0;
			pdown_r  <= 1'b0;
		end else begin
			expiry_r <= warm_reset | (ovf_sleep & in_run) |              // RQ7 RQ8
				(expiry_r & ~i_wdt_clear_instr & ~i_halt_instr);
			pdown_r  <= i_halt_instr | (pdown_r & ~i_wdt_clear_instr);
		end
	end

	// ****************************************
	// Outputs to core and ports
	// ****************************************
	// Slow clock sampling, sleep wake clear and power-on port preset
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slow_osc_r    <= 1'b0;
			pc_sp_clr_r   <= 1'b0;
			port_preset_r <= 1'b1;
		end else begin
			slow_osc_r    <= i_slow_osc;
			pc_sp_clr_r   <= ovf_sleep & in_run & ~pin_low;             // RQ8
			port_preset_r <= 1'b0;                                      // RQ16
		end
	end

	// Wishbone answer one cycle after the request
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_r  <= 1'b0;
			rdat_r <= '0;
		end else begin
			ack_r  <= wb_req;
			rdat_r <= wb_req ? rd_mux : rdat_r;
		end
	end

	assign o_wb_ack          = ack_r;
	assign o_wb_dat          = rdat_r;
	assign o_core_reset      = core_rst;                                 // RQ15
	assign o_pc_sp_clear     = pc_sp_clr_r;
	assign o_port_preset     = port_preset_r;
	assign o_reset_pin_mode  = pin_mode;
	assign o_expiry_flag     = expiry_r;
	assign o_power_down_flag = pdown_r;

	// ****************************************
	// Checks
	// ****************************************
	localparam int A_ERR_MAX = 20;

	a_key_err_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ4
		in_run && en_key_bad && !pin_low && !ovf_run |-> ##[1:A_ERR_MAX] state_r == ST_RESET)
		else $error("bad enable key did not reset");

	a_pin_key_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ12
		in_run && pin_key_bad && !pin_low && !ovf_run |-> ##[1:A_ERR_MAX] o_core_reset)
		else $error("bad pin key did not reset");

	a_wrf_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ6
		cause_r[CF_WDT_KEY] && !(wr_cau && !i_wb_dat[0]) |=> cause_r[CF_WDT_KEY])
		else $error("enable key flag lost without software clear");

	a_pin_flag_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ19
		state_r == ST_KEY_WAIT && err_pin_r ##1 state_r == ST_RESET |=> cause_r[CF_PIN_KEY])
		else $error("pin key flag not set");

	a_run_timeout: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ7
		in_run && ovf_run && !pin_low |=> o_core_reset ##1 (expiry_r && !o_core_reset))
		else $error("running overflow did not reset");

	a_sleep_warm: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ8
		in_run && ovf_sleep && !pin_low |=> o_pc_sp_clear && expiry_r && !o_core_reset)
		else $error("sleep overflow handled wrongly");

	a_disabled_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ21
		!wdt_on |=> timer_count == '0)
		else $error("counter moved while disabled");

	a_halt_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ18
		i_halt_instr |=> timer_count == '0 && pdown_r)
		else $error("halt did not clear counter");

	a_pin_delay: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ14
		hold_exit |=> o_core_reset [*8])
		else $error("no delay after pin release");

	a_pin_key_por: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ20
		full_reset |=> pin_key_r == PIN_KEY_POR && wdt_ctrl_r == WDT_CTRL_POR)
		else $error("full reset kept keys");

	a_upper_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ17
		wb_req && !i_wb_we && sel_cau |=> o_wb_ack && o_wb_dat[31:4] == 28'h0000000)
		else $error("flag register upper bits not zero");

	// Key error wait runs its full delay before the reset
	a_key_wait_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ4
		state_r == ST_KEY_WAIT && dly_r < KEY_ERR_LAST |=> state_r == ST_KEY_WAIT)
		else $error("key error reset came early");

	// Pin held low in reset mode resets the device
	a_pin_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ11
		in_run && pin_mode && !i_reset_pin_n |=> o_core_reset)
		else $error("reset pin low did not reset");

	// Pin low in shared I/O mode leaves the device running
	a_io_mode_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ11
		in_run && !pin_mode && !i_reset_pin_n && !ovf_run && !any_key_bad |=> !o_core_reset)
		else $error("pin low reset in shared mode");

	// Port preset ends one edge after reset release
	a_port_preset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ16
		o_port_preset |=> !o_port_preset)
		else $error("port preset did not end");

	// Timeout warm reset keeps the pin key
	a_warm_keeps_pin: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ20
		warm_reset |=> $stable(pin_key_r))
		else $error("warm reset changed pin key");

	// Sleep expiry clears PC and SP for one cycle only
	a_pc_sp_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ8
		o_pc_sp_clear |=> !o_pc_sp_clear)
		else $error("PC and SP clear longer than one cycle");

	// Clear instruction empties the counter
	a_clear_instr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ9
		i_wdt_clear_instr |=> timer_count == '0)
		else $error("clear instruction left count");

	// Undefined enable key empties the counter
	a_bad_key_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RQ9
		en_key_bad |=> timer_count == '0)
		else $error("bad enable key left count");

endmodule

// >>> rtl/wdc_pkg.sv
// What this block does
// RQ1 - Watchdog counts slow internal oscillator edges only
// RQ2 - Period codes select 2^8 up to 2^18
// RQ3 - Enable key 10101B disables, 01010B enables
// RQ4 - Other enable key: delayed reset, set flag
// RQ5 - Enable key powers up as 01010B
// RQ6 - Enable-key flag cleared only by software zero
// RQ7 - Running overflow resets device, sets expiry flag
// RQ8 - Sleep overflow sets flag, clears PC, SP
// RQ9 - Bad key, clear, halt, pin clear counter
// RQ10 - Software clears with dedicated clear instruction
// RQ11 - Pin key 55h shared I/O, AAh reset
// RQ12 - Other pin key resets after delay
// RQ13 - Pin key powers up as 01010101B
// RQ14 - Extra delay after reset pin release
// RQ15 - Every reset restarts program at zero
// RQ16 - Power-on sets all port registers high
// RQ17 - Upper four flag bits read zero
// RQ18 - Halt clears counter, resumes only if enabled
// RQ19 - Bad pin key reset sets pin flag
// RQ20 - Resets restore pin key except timeout
// RQ21 - Counter held zero while disabled
// RQ22 - Key checks run continuously, no strobe
package wdc_pkg;

	// ****************************************
	// Bus layout and register offsets
	// ****************************************
	localparam int        WB_AW        = 8;
	localparam int        WB_DW        = 32;
	localparam logic [7:0] ADR_WDT_CTRL = 8'h00;
	localparam logic [7:0] ADR_PIN_KEY  = 8'h04;
	localparam logic [7:0] ADR_CAUSE    = 8'h08;
	localparam logic [7:0] ADR_STATUS   = 8'h0C;

	// ****************************************
	// Fields, codes and reset values
	// ****************************************
	localparam logic [7:0] WDT_CTRL_POR   = 8'h53;
	localparam int         EN_KEY_MSB     = 7;
	localparam int         EN_KEY_LSB     = 3;
	localparam int         PSEL_MSB       = 2;
	localparam int         PSEL_LSB       = 0;
	localparam logic [4:0] EN_KEY_DISABLE = 5'h15;
	localparam logic [4:0] EN_KEY_ENABLE  = 5'h0A;
	localparam logic [7:0] PIN_KEY_IO     = 8'h55;
	localparam logic [7:0] PIN_KEY_RESET  = 8'hAA;
	localparam logic [7:0] PIN_KEY_POR    = 8'h55;
	localparam int         CF_WDT_KEY     = 0;
	localparam int         CF_BO_KEY      = 1;
	localparam int         CF_BO          = 2;
	localparam int         CF_PIN_KEY     = 3;
	localparam logic [3:0] CAUSE_POR      = 4'h0;
	localparam int         ST_EXPIRY      = 0;
	localparam int         ST_PDOWN       = 1;

	// ****************************************
	// Timing
	// ****************************************
	localparam int         SLOW_OSC_HZ        = 32000;
	localparam int         CLK_PERIOD_NS      = 10;
	localparam int         KEY_ERR_DELAY_NS   = 160;
	localparam int         PIN_RESET_DELAY_NS = 320;
	localparam int         KEY_ERR_DELAY_CYC  =
		(KEY_ERR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         PIN_RESET_DELAY_CYC =
		(PIN_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         DLY_W              = 6;
	localparam logic [DLY_W-1:0] KEY_ERR_LAST = DLY_W'(KEY_ERR_DELAY_CYC - 1);
	localparam logic [DLY_W-1:0] PIN_DLY_LAST = DLY_W'(PIN_RESET_DELAY_CYC - 1);
	localparam int         WDT_CNT_W          = 18;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_RUN       = 3'h0,
		ST_KEY_WAIT  = 3'h1,
		ST_RESET     = 3'h3,
		ST_PIN_HOLD  = 3'h4,
		ST_PIN_DELAY = 3'h5
	} wdc_state_t;

	// Last count before overflow for each period code
	function automatic logic [WDT_CNT_W-1:0] wdc_period_last(input logic [2:0] sel);
		logic [WDT_CNT_W-1:0] r;
		r = 18'h000FF;
		unique case (sel) // RQ2
			3'h0: r = 18'h000FF;
			3'h1: r = 18'h003FF;
			3'h2: r = 18'h00FFF;
			3'h3: r = 18'h03FFF;
			3'h4: r = 18'h07FFF;
			3'h5: r = 18'h0FFFF;
			3'h6: r = 18'h1FFFF;
			3'h7: r = 18'h3FFFF;
		endcase
		return r;
	endfunction

endpackage

// >>> rtl/wdc_timer.sv
`timescale 1ns/10ps
module wdc_timer import wdc_pkg::*; (
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_tick,
	input  wire logic                 i_clear,
	input  wire logic                 i_enable,
	input  wire logic [2:0]           i_period_sel,
	output logic      [WDT_CNT_W-1:0] o_count,
	output logic                      o_overflow
);

	// ****************************************
	// Prescaled watchdog count
	// ****************************************
	logic [WDT_CNT_W-1:0] count_r;
	logic [WDT_CNT_W-1:0] count_nxt;
	logic                 ovf_r;
	wire                  at_last = (count_r == wdc_period_last(i_period_sel));
	wire                  ovf_nxt = i_enable & ~i_clear & i_tick & at_last; // RQ21

	// Clear wins, disabled holds zero, slow ticks advance
	assign count_nxt = (i_clear | ~i_enable) ? '0 :      // RQ9 RQ18 RQ21
		~i_tick ? count_r :                             // RQ1
		at_last ? '0 : count_r + 1'b1;

	// Count and overflow pulse
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_r <= '0;
			ovf_r   <= 1'b0;
		end else begin
			count_r <= count_nxt;
			ovf_r   <= ovf_nxt;
		end
	end

	assign o_count    = count_r;
	assign o_overflow = ovf_r;

endmodule

// >>> sim/tb_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb_top import wdc_pkg::*;;
	logic             i_sys_clk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we;
	logic [WB_AW-1:0] i_wb_adr;
	logic [3:0]       i_wb_sel;
	logic [WB_DW-1:0] i_wb_dat;
	logic [WB_DW-1:0] o_wb_dat;
	logic             o_wb_ack, i_slow_osc, i_wdt_clear_instr, i_halt_instr, i_low_power;
	logic             i_reset_pin_n, o_core_reset, o_pc_sp_clear, o_port_preset;
	logic             o_reset_pin_mode, o_expiry_flag, o_power_down_flag;
	int               n_mismatch, samples_checked, n_rst, n_pcsp, cyc_cnt, base, r, k;
	logic [7:0]       bad;

	wdc_reset_ctrl wdc_reset_ctrl_inst (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_slow_osc(i_slow_osc),
		.i_wdt_clear_instr(i_wdt_clear_instr), .i_halt_instr(i_halt_instr),
		.i_low_power(i_low_power), .i_reset_pin_n(i_reset_pin_n),
		.o_core_reset(o_core_reset), .o_pc_sp_clear(o_pc_sp_clear),
		.o_port_preset(o_port_preset), .o_reset_pin_mode(o_reset_pin_mode),
		.o_expiry_flag(o_expiry_flag), .o_power_down_flag(o_power_down_flag));

	// ****************************************
	// Clock, event counters and timeout
	// ****************************************
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	// Counts cycles with reset or PC/SP clear high on the falling edge, where outputs are settled
	always @(negedge i_sys_clk) begin
		cyc_cnt++;
		if (o_core_reset === 1'b1) n_rst++;
		if (o_pc_sp_clear === 1'b1) n_pcsp++;
		if (cyc_cnt == 40000) begin
			n_mismatch++;
			$display("ERROR t=%0t run did not complete", $time);
			give_verdict();
		end
	end

	// ****************************************
	// Tasks and expectation functions
	// ****************************************
	task automatic give_verdict();
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask

	// Classic single Wishbone cycle, released at the ack edge or after 50 edges without one
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
		output logic [WB_DW-1:0] rd);
		int t;
		t = 0;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we  <= we;
		i_wb_sel <= 4'hF;
		i_wb_adr <= adr;
		i_wb_dat <= {24'h000000, wd};
		do begin
			@(posedge i_sys_clk);
			t++;
		end while (o_wb_ack !== 1'b1 && t < 50);
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we  <= 1'b0;
		if (t >= 50) begin
			n_mismatch++;
			$display("ERROR t=%0t bus cycle not answered", $time);
		end
		@(posedge i_sys_clk);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		logic [WB_DW-1:0] rd;
		wb_xfer(1'b1, adr, d, rd);
	endtask

	task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
		logic [WB_DW-1:0] rd;
		wb_xfer(1'b0, adr, 8'h00, rd);
		`CHK(rd, {24'h000000, exp})
	endtask

	// One slow oscillator period: high for a cycle, then low for a cycle
	task automatic tick(input int n);
		repeat (n) begin
			i_slow_osc <= 1'b1;
			@(posedge i_sys_clk);
			i_slow_osc <= 1'b0;
			@(posedge i_sys_clk);
		end
	endtask

	task automatic watchdog_clear_instruction();
		i_wdt_clear_instr <= 1'b1;
		@(posedge i_sys_clk);
		i_wdt_clear_instr <= 1'b0;
		@(posedge i_sys_clk);
	endtask

	function automatic int exp_ticks(input int code);
		return (code == 0) ? 256 : (code < 4) ? (1 << (8 + 2 * code)) : (1 << (11 + code));
	endfunction

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_slow_osc, i_wdt_clear_instr} = '0;
		{i_halt_instr, i_low_power} = '0;
		i_wb_adr = '0;
		i_wb_dat = '0;
		i_wb_sel = 4'hF;
		i_reset_pin_n = 1'b1;
		{n_mismatch, samples_checked, n_rst, n_pcsp, cyc_cnt} = '0;
		void'($urandom(32'h425C));
		cyc(2);
		`CHK(o_port_preset, 1'b1);
		i_rst_n <= 1'b1;
		@(posedge i_sys_clk);
		rd_chk(ADR_WDT_CTRL, WDT_CTRL_POR);
		`CHK(o_port_preset, 1'b0);
		rd_chk(ADR_PIN_KEY, PIN_KEY_POR);
		rd_chk(ADR_CAUSE, {4'h0, CAUSE_POR});
		rd_chk(8'h40, 8'h00);
		`CHK(o_reset_pin_mode, 1'b0);
		// Timeout for the short period codes, one tick short and exact
		for (k = 0; k < 3; k++) begin
			wr(ADR_WDT_CTRL, {EN_KEY_ENABLE, 3'(k)});
			watchdog_clear_instruction();
			base = n_rst;
			tick(exp_ticks(k) - 1);
			cyc(4);
			`CHK(n_rst, base);
			tick(1);
			cyc(4);
			`CHK(n_rst, base + 1);
			`CHK(o_expiry_flag, 1'b1);
			rd_chk(ADR_WDT_CTRL, {EN_KEY_ENABLE, 3'(k)});
		end
		// Long period codes outlast the longest short code tested
		r = $urandom_range(7, 3);
		wr(ADR_WDT_CTRL, {EN_KEY_ENABLE, 3'(r)});
		watchdog_clear_instruction();
		base = n_rst;
		tick(exp_ticks(2));
		cyc(4);
		`CHK(n_rst, base);
		rd_chk(ADR_WDT_CTRL, {EN_KEY_ENABLE, 3'(r)});
		// Clear instruction at a random point restarts the count
		wr(ADR_WDT_CTRL, {EN_KEY_ENABLE, 3'h0});
		watchdog_clear_instruction();
		`CHK(o_expiry_flag, 1'b0);
		base = n_rst;
		r = $urandom_range(254, 1);
		tick(r);
		watchdog_clear_instruction();
		tick(255);
		cyc(4);
		`CHK(n_rst, base);
		// Halt clears the counter and sets power-down; counting resumes
		watchdog_clear_instruction();
		tick(200);
		i_halt_instr <= 1'b1;
		@(posedge i_sys_clk);
		i_halt_instr <= 1'b0;
		cyc(2);
		`CHK(o_power_down_flag, 1'b1);
		tick(255);
		cyc(4);
		`CHK(n_rst, base);
		tick(1);
		cyc(4);
		`CHK(n_rst, base + 1);
		watchdog_clear_instruction();
		`CHK(o_power_down_flag, 1'b0);
		// Disabled watchdog never expires, re-enabled one does
		wr(ADR_WDT_CTRL, {EN_KEY_DISABLE, 3'h0});
		base = n_rst;
		tick(300);
		cyc(4);
		`CHK(n_rst, base);
		wr(ADR_WDT_CTRL, {EN_KEY_ENABLE, 3'h0});
		tick(256);
		cyc(4);
		`CHK(n_rst, base + 1);
		// Expiry while asleep clears PC and SP only
		i_low_power <= 1'b1;
		watchdog_clear_instruction();
		base = n_rst;
		r = n_pcsp;
		tick(256);
		cyc(4);
		`CHK(n_pcsp, r + 1);
		`CHK(n_rst, base);
		`CHK(o_expiry_flag, 1'b1);
		rd_chk(ADR_STATUS, 8'h01);
		i_low_power <= 1'b0;
		// Undefined enable key forces a delayed reset and a sticky flag
		do bad = 8'($urandom_range(31, 0)); while (bad == 8'h0A || bad == 8'h15);
		wr(ADR_WDT_CTRL, {bad[4:0], 3'h0});
		base = n_rst;
		cyc(KEY_ERR_DELAY_CYC - 3);
		`CHK(n_rst, base);
		cyc(6);
		`CHK(n_rst, base + 1);
		rd_chk(ADR_CAUSE, 8'h01);
		rd_chk(ADR_WDT_CTRL, WDT_CTRL_POR);
		wr(ADR_CAUSE, 8'hFF);
		rd_chk(ADR_CAUSE, 8'h01);
		// Undefined pin key forces a delayed reset and sets its flag
		do bad = 8'($urandom()); while (bad == PIN_KEY_IO || bad == PIN_KEY_RESET);
		wr(ADR_PIN_KEY, bad);
		base = n_rst;
		cyc(KEY_ERR_DELAY_CYC - 3);
		`CHK(n_rst, base);
		cyc(6);
		`CHK(n_rst, base + 1);
		rd_chk(ADR_CAUSE, 8'h09);
		rd_chk(ADR_PIN_KEY, PIN_KEY_POR);
		wr(ADR_CAUSE, 8'h00);
		rd_chk(ADR_CAUSE, 8'h00);
		// Pin low is ignored in shared I/O mode
		i_reset_pin_n <= 1'b0;
		cyc(4);
		`CHK(o_core_reset, 1'b0);
		i_reset_pin_n <= 1'b1;
		cyc(2);
		// Reset pin mode: held reset, then the extra release delay
		wr(ADR_PIN_KEY, PIN_KEY_RESET);
		`CHK(o_reset_pin_mode, 1'b1);
		i_reset_pin_n <= 1'b0;
		cyc(5);
		`CHK(o_core_reset, 1'b1);
		i_reset_pin_n <= 1'b1;
		cyc(PIN_RESET_DELAY_CYC - 3);
		`CHK(o_core_reset, 1'b1);
		cyc(6);
		`CHK(o_core_reset, 1'b0);
		`CHK(o_reset_pin_mode, 1'b0);
		rd_chk(ADR_PIN_KEY, PIN_KEY_POR);
		// Mid-run power-on reset restores both keys and presets the ports
		wr(ADR_PIN_KEY, PIN_KEY_RESET);
		wr(ADR_WDT_CTRL, {EN_KEY_DISABLE, 3'h5});
		i_rst_n <= 1'b0;
		cyc(2);
		`CHK(o_port_preset, 1'b1);
		i_rst_n <= 1'b1;
		cyc(2);
		`CHK(o_port_preset, 1'b0);
		rd_chk(ADR_WDT_CTRL, WDT_CTRL_POR);
		rd_chk(ADR_PIN_KEY, PIN_KEY_POR);
		`CHK(o_reset_pin_mode, 1'b0);
		give_verdict();
	end
endmodule
